// *** src/ues_top.sv ***
// USB device event flags, function address and endpoint status over APB
//
// How it works
// RL1: Endpoint 1 event sets its flag; cleared by writing one to it or bit 1.
// RL2: Endpoint 0 event sets its flag; cleared by writing one to it or bit 1.
// RL3: Wake-up event sets a sticky flag cleared by writing one to bit 3.
// RL4: Attach or detach sets a sticky flag cleared by writing one to bit 2.
// RL5: Setup, IN, OUT ACK and isochronous events set the transaction flag.
// RL6: Transaction flag clears on write one, or once all endpoint/setup flags cleared.
// RL7: Suspend/resume sets link flag; cause kept in four bits; write one clears.
// RL8: Seven-bit writable device address, reset zero, used to match bus tokens.
// RL9: Read-only endpoint status, reset zero, three bits per endpoint, 5..3 high.
// RL10: Code 000 after IN ACK from host, 001 after IN answered with NAK.
// RL11: Code 010 after OUT DATA0 ACK, 110 after OUT DATA1 ACK.
// RL12: Code 011 after SETUP ACK, 111 when an isochronous transfer ends.
// RL13: Endpoints 2, 1, 0 fields sit below endpoint 3 with the same coding.
// RL14: Overrun set when OUT exceeds max payload or SETUP exceeds 8 bytes.
// RL15: Setup flag in bit 31 set by SETUP, cleared only by writing one.
// RL16: A new event wins over a clear in the same cycle.
// RL17: Reserved bits read zero and ignore writes.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ues_top
   import ues_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [UES_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ues_ep_evt_t ep_evt,
   input wire ues_bus_evt_t bus_evt,
   input wire logic [UES_DEVICE_ADDRESS_FIELD_W-1:0] tok_addr,
   output logic [UES_DEVICE_ADDRESS_FIELD_W-1:0] device_address_field,
   output logic addr_match,
   output logic [UES_CAUSE_W-1:0] link_cause
);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta_q;
   logic rst_n_q;

   // Assertion is immediate, release waits two edges to avoid metastability
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   ues_apb_state_t ap_state_q;
   ues_apb_state_t ap_state_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic err_q;
   logic err_d;
   logic setup_phase;
   logic commit;
   logic wr_commit;
   logic hit_event;
   logic hit_addr;
   logic hit_epst;
   logic [31:0] event_word;
   logic [31:0] epst_word;

   assign setup_phase = psel && !penable;
   assign commit = psel && penable && (ap_state_q == UES_AP_ACCESS);
   assign wr_commit = commit && pwrite && !err_q;
   assign hit_event = (paddr == UES_OFF_EVENT);
   assign hit_addr = (paddr == UES_OFF_ADDR);
   assign hit_epst = (paddr == UES_OFF_EPST);

   // Read data is captured in the setup cycle so it comes from a flop;
   // an event in that one cycle shows on the next read instead
   always_comb
   begin
      ap_state_d = ap_state_q;
      rdata_d = rdata_q;
      err_d = err_q;
      case (ap_state_q)
         UES_AP_IDLE:
         begin
            if (setup_phase)
            begin
               ap_state_d = UES_AP_ACCESS;
               err_d = !(hit_event || hit_addr || hit_epst) || (pwrite && hit_epst);
               rdata_d = UES_RST_WORD;
               if (!pwrite && hit_event)
               begin
                  rdata_d = event_word & UES_EVT_MASK; // RL17
               end
               if (!pwrite && hit_addr)
               begin
                  rdata_d = {{(32-UES_DEVICE_ADDRESS_FIELD_W){1'b0}}, device_address_field}; // RL17
               end
               if (!pwrite && hit_epst)
               begin
                  rdata_d = epst_word;
               end
            end
         end
         UES_AP_ACCESS:
         begin
            if (commit)
            begin
               ap_state_d = UES_AP_IDLE;
            end
            if (!psel)
            begin
               ap_state_d = UES_AP_IDLE;
            end
         end
         default:
         begin
            ap_state_d = UES_AP_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         ap_state_q <= UES_AP_IDLE;
         rdata_q <= UES_RST_WORD;
         err_q <= 1'b0;
      end
      else
      begin
         ap_state_q <= ap_state_d;
         rdata_q <= rdata_d;
         err_q <= err_d;
      end
   end

   assign pready = (ap_state_q == UES_AP_ACCESS);
   assign pslverr = pready && err_q;
   assign prdata = rdata_q;

   // ----------------------------------------
   // Event status flags
   // ----------------------------------------
   logic ep_ok;
   logic [31:0] evt_set;
   logic [31:0] evt_clr;
   logic [31:0] w1c;
   logic chain_clear;
   logic wr_event;

   assign ep_ok = ep_evt.valid && (ep_evt.num < 3'(UES_NUM_EP));
   assign wr_event = wr_commit && hit_event;
   assign w1c = wr_event ? (pwdata & UES_EVT_MASK) : UES_RST_WORD; // RL17

   // Clearing the last pending endpoint or setup flag also retires the
   // transaction flag, so software need not clear it separately
   assign chain_clear = wr_event && ((w1c & UES_CHAIN_MASK) != UES_RST_WORD)
      && ((event_word & ~w1c & UES_CHAIN_MASK) == UES_RST_WORD); // RL6

   always_comb
   begin
      evt_set = UES_RST_WORD;
      evt_clr = w1c; // RL3 RL4 RL7 RL15
      for (int i = 0; i < UES_NUM_EP; i++)
      begin
         evt_set[UES_B_EP0 + i] = ep_ok && (ep_evt.num == 3'(i)); // RL1 RL2
         if (w1c[UES_B_TXN])
         begin
            evt_clr[UES_B_EP0 + i] = 1'b1; // RL1 RL2
         end
      end
      evt_set[UES_B_TXN] = ep_ok || bus_evt.setup; // RL5
      if (chain_clear)
      begin
         evt_clr[UES_B_TXN] = 1'b1; // RL6
      end
      evt_set[UES_B_SETUP] = bus_evt.setup; // RL15
      evt_set[UES_B_WAKE] = bus_evt.wake; // RL3
      evt_set[UES_B_ATTACH] = bus_evt.attach_detach; // RL4
      evt_set[UES_B_LINK] = bus_evt.link_change; // RL7
   end

   genvar g;
   generate
      for (g = 0; g < 32; g++)
      begin : g_evt
         if (UES_EVT_MASK[g])
         begin : g_flag
            ues_flag_cell u_flag
            (
               .clk(sys_clk),
               .rst_n(rst_n_q),
               .set(evt_set[g]),
               .clr(evt_clr[g]),
               .flag(event_word[g])
            );
         end
         else
         begin : g_rsvd
            assign event_word[g] = 1'b0; // RL17
         end
      end
   endgenerate

   // ----------------------------------------
   // Link cause and device address
   // ----------------------------------------
   logic [UES_CAUSE_W-1:0] cause_q;
   logic [UES_CAUSE_W-1:0] cause_d;
   logic [UES_DEVICE_ADDRESS_FIELD_W-1:0] device_address_field_q;
   logic [UES_DEVICE_ADDRESS_FIELD_W-1:0] device_address_field_d;

   always_comb
   begin
      cause_d = cause_q;
      device_address_field_d = device_address_field_q;
      if (bus_evt.link_change)
      begin
         cause_d = bus_evt.link_cause; // RL7
      end
      if (wr_commit && hit_addr)
      begin
         device_address_field_d = pwdata[UES_DEVICE_ADDRESS_FIELD_W-1:0]; // RL8 RL17
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         cause_q <= UES_RST_WORD[UES_CAUSE_W-1:0];
         device_address_field_q <= UES_RST_WORD[UES_DEVICE_ADDRESS_FIELD_W-1:0]; // RL8
      end
      else
      begin
         cause_q <= cause_d;
         device_address_field_q <= device_address_field_d;
      end
   end

   assign link_cause = cause_q;
   assign device_address_field = device_address_field_q;
   assign addr_match = (tok_addr == device_address_field_q); // RL8

   // ----------------------------------------
   // Endpoint status codes and overrun
   // ----------------------------------------
   logic [UES_CODE_W-1:0] code_q [UES_NUM_EP];
   logic [UES_CODE_W-1:0] code_d [UES_NUM_EP];
   logic ovr_q;
   logic ovr_d;
   logic [UES_LEN_W-1:0] len_limit;

   // A SETUP stage is bounded by the fixed request size, OUT by the payload
   assign len_limit = (ep_evt.code == UES_SETUP_ACK) ? UES_SETUP_MAX : ep_evt.max_payload;

   always_comb
   begin
      ovr_d = ovr_q;
      for (int i = 0; i < UES_NUM_EP; i++)
      begin
         code_d[i] = code_q[i];
         if (ep_ok && (ep_evt.num == 3'(i)))
         begin
            code_d[i] = ep_evt.code; // RL10 RL11 RL12
         end
      end
      if (ep_ok)
      begin
         // Only OUT and SETUP carry received data that can overrun
         case (ep_evt.code)
            UES_OUT0_ACK, UES_OUT1_ACK, UES_SETUP_ACK:
            begin
               ovr_d = (ep_evt.len > len_limit); // RL14
            end
            default:
            begin
               ovr_d = 1'b0; // RL14
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         for (int i = 0; i < UES_NUM_EP; i++)
         begin
            code_q[i] <= UES_IN_ACK; // RL9
         end
         ovr_q <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < UES_NUM_EP; i++)
         begin
            code_q[i] <= code_d[i];
         end
         ovr_q <= ovr_d;
      end
   end

   always_comb
   begin
      epst_word = UES_RST_WORD; // RL17
      epst_word[UES_B_OVERRUN] = ovr_q; // RL14
      for (int i = 0; i < UES_NUM_EP; i++)
      begin
         epst_word[UES_EPST_LSB + UES_CODE_W*i +: UES_CODE_W] = code_q[i]; // RL9 RL13
      end
   end

endmodule
`default_nettype wire

// *** src/ues_pkg.sv ***
// Shared constants and types for the USB device event and status block
package ues_pkg;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam int UES_ADDR_W = 12;
   localparam logic [UES_ADDR_W-1:0] UES_OFF_EVENT = 12'h004;
   localparam logic [UES_ADDR_W-1:0] UES_OFF_ADDR = 12'h008;
   localparam logic [UES_ADDR_W-1:0] UES_OFF_EPST = 12'h00c;
   localparam logic [31:0] UES_RST_WORD = 32'h0000_0000;

   // ----------------------------------------
   // Event status fields
   // ----------------------------------------
   localparam int UES_B_LINK = 0;
   localparam int UES_B_TXN = 1;
   localparam int UES_B_ATTACH = 2;
   localparam int UES_B_WAKE = 3;
   localparam int UES_B_EP0 = 16;
   localparam int UES_B_SETUP = 31;
   localparam int UES_NUM_EP = 6;
   localparam logic [31:0] UES_EVT_MASK = 32'h803f_000f;
   localparam logic [31:0] UES_EP_MASK = 32'h003f_0000;
   localparam logic [31:0] UES_CHAIN_MASK = 32'h803f_0000;

   // ----------------------------------------
   // Address and endpoint status fields
   // ----------------------------------------
   localparam int UES_DEVICE_ADDRESS_FIELD_W = 7;
   localparam int UES_CODE_W = 3;
   localparam int UES_EPST_LSB = 8;
   localparam int UES_B_OVERRUN = 7;
   localparam int UES_LEN_W = 10;
   localparam logic [UES_LEN_W-1:0] UES_SETUP_MAX = 10'h008;
   localparam int UES_CAUSE_W = 4;

   typedef enum logic [UES_CODE_W-1:0] {
      UES_IN_ACK = 3'h0,
      UES_IN_NAK = 3'h1,
      UES_OUT0_ACK = 3'h2,
      UES_SETUP_ACK = 3'h3,
      UES_OUT1_ACK = 3'h6,
      UES_ISO_END = 3'h7
   } ues_code_t;

   typedef enum logic [0:0] {
      UES_AP_IDLE = 1'b0,
      UES_AP_ACCESS = 1'b1
   } ues_apb_state_t;

   // One completed endpoint transaction reported by the serial engine
   typedef struct packed {
      logic valid;
      logic [2:0] num;
      ues_code_t code;
      logic [UES_LEN_W-1:0] len;
      logic [UES_LEN_W-1:0] max_payload;
   } ues_ep_evt_t;

   // One-cycle bus-level event pulses
   typedef struct packed {
      logic setup;
      logic wake;
      logic attach_detach;
      logic link_change;
      logic [UES_CAUSE_W-1:0] link_cause;
   } ues_bus_evt_t;

endpackage

// *** src/ues_flag_cell.sv ***
// Sticky event flag, set by hardware and cleared by a write of one
`timescale 1ns/1ps
`default_nettype none
module ues_flag_cell
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic set,
   input wire logic clr,
   output logic flag
);

   logic flag_q;
   logic flag_d;

   // Set is checked last so a clear in the same cycle cannot lose it
   always_comb
   begin
      flag_d = flag_q;
      if (clr)
      begin
         flag_d = 1'b0;
      end
      if (set)
      begin
         flag_d = 1'b1; // RL16
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_q <= 1'b0;
      end
      else
      begin
         flag_q <= flag_d;
      end
   end

   assign flag = flag_q;

endmodule
`default_nettype wire

// *** tb/ues_checker.sv ***
// Port checker for the USB device event and status block
`timescale 1ns/1ps
`default_nettype none
module ues_checker
   import ues_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [UES_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire ues_ep_evt_t ep_evt,
   input wire ues_bus_evt_t bus_evt,
   input wire logic [UES_DEVICE_ADDRESS_FIELD_W-1:0] tok_addr,
   input wire logic [UES_DEVICE_ADDRESS_FIELD_W-1:0] device_address_field,
   input wire logic addr_match,
   input wire logic [UES_CAUSE_W-1:0] link_cause
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   sequence s_setup(a, w);
      psel && !penable && paddr == a && pwrite == w;
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence
   property p_addr_wr;
      s_setup(UES_OFF_ADDR, 1'b1) ##1 s_done |=> device_address_field == $past(pwdata[6:0]);
   endproperty
   a_addr_wr: assert property (p_addr_wr) else $error("address not stored");
   property p_addr_hold;
      !(psel && penable && pwrite && paddr == UES_OFF_ADDR) |=> $stable(device_address_field);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved");
   property p_match;
      addr_match == (tok_addr == device_address_field);
   endproperty
   a_match: assert property (p_match) else $error("address match wrong");
   property p_addr_rd;
      s_setup(UES_OFF_ADDR, 1'b0) |=> prdata == {25'h0, device_address_field};
   endproperty
   a_addr_rd: assert property (p_addr_rd) else $error("address read wrong");
   property p_cause_cap;
      bus_evt.link_change |=> link_cause == $past(bus_evt.link_cause);
   endproperty
   a_cause_cap: assert property (p_cause_cap) else $error("cause not taken");
   property p_cause_hold;
      !bus_evt.link_change |=> $stable(link_cause);
   endproperty
   a_cause_hold: assert property (p_cause_hold) else $error("cause moved");
   property p_epst_ro;
      s_setup(UES_OFF_EPST, 1'b1) |=> pready && pslverr;
   endproperty
   a_epst_ro: assert property (p_epst_ro) else $error("status write accepted");
   property p_rsv_epst;
      s_setup(UES_OFF_EPST, 1'b0) |=> prdata[31:26] == 6'h0 && prdata[6:0] == 7'h0;
   endproperty
   a_rsv_epst: assert property (p_rsv_epst) else $error("status spare bits set");
   property p_rsv_evt;
      s_setup(UES_OFF_EVENT, 1'b0) |=> (prdata & ~UES_EVT_MASK) == 32'h0;
   endproperty
   a_rsv_evt: assert property (p_rsv_evt) else $error("event spare bits set");
endmodule
bind ues_top ues_checker u_chk (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .ep_evt, .bus_evt, .tok_addr, .device_address_field,
   .addr_match, .link_cause);
`default_nettype wire

// *** tb/ues_host_model.sv ***
// Host side model that reports completed bus events
`timescale 1ns/1ps
`default_nettype none
module ues_host_model
   import ues_pkg::*;
(
   input wire logic sys_clk,
   output ues_ep_evt_t ep_evt,
   output ues_bus_evt_t bus_evt,
   output logic [UES_DEVICE_ADDRESS_FIELD_W-1:0] tok_addr
);
   initial
   begin
      ep_evt = '0;
      bus_evt = '0;
      tok_addr = '0;
   end
   // Fields go to junk after a pulse, so a design that ignores valid is caught
   task automatic ep(input logic [2:0] n, input logic [2:0] c, input logic [9:0] len,
      input logic [9:0] mp);
      ep_evt <= '{1'b1, n, ues_code_t'(c), len, mp};
      @(posedge sys_clk);
      ep_evt <= '{1'b0, ~n, ues_code_t'(~c), ~len, ~mp};
   endtask
   task automatic bus(input ues_bus_evt_t b);
      bus_evt <= b;
      @(posedge sys_clk);
      bus_evt <= {4'h0, ~b.link_cause};
   endtask
   task automatic tok(input logic [6:0] a);
      tok_addr <= a;
   endtask
endmodule
`default_nettype wire

// *** tb/ues_top_tb.sv ***
// Self-checking bench for the USB device event and status block
`timescale 1ns/1ps
`default_nettype none
module ues_top_tb import ues_pkg::*;;
   logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, addr_match;
   logic [UES_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, ev, ep;
   ues_ep_evt_t ep_evt;
   ues_bus_evt_t bus_evt;
   logic [6:0] tok_addr, dev_addr, fa;
   logic [3:0] cause, cr;
   logic [33:0] exp_q[$];
   logic [33:0] e;
   logic [9:0] ln, mp;
   logic [2:0] codes[6] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h3, 3'h7};
   int n_fail = 0;
   int tests_run = 0;
   ues_top uut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ep_evt, .bus_evt, .tok_addr, .device_address_field(dev_addr),
      .addr_match, .link_cause(cause));
   ues_host_model host (.sys_clk, .ep_evt, .bus_evt, .tok_addr);
   initial
   begin
      sys_clk = 0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Read data is only judged on reads; every access judges the error flag
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      exp_q.push_back({!w, (a != UES_OFF_EVENT && a != UES_OFF_ADDR && a != UES_OFF_EPST)
         || (w && a == UES_OFF_EPST), d});
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= w ? d : $urandom;
      @(posedge sys_clk);
      penable <= 1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
      @(posedge sys_clk);
   endtask
   always @(posedge sys_clk)
      if (psel && penable && pready === 1'b1)
      begin
         e = exp_q.pop_front();
         chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
         if (e[33])
            chk("prdata", e[31:0], prdata);
      end
   task automatic test_done;
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      n_fail++;
      test_done;
   end
   initial
   begin
      arst_n = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = '0;
      pwdata = '0;
      ev = '0;
      ep = '0;
      void'($urandom(32'h31d6));
      repeat (16) @(posedge sys_clk);
      arst_n <= 1;
      repeat (3) @(posedge sys_clk);
      apb(0, UES_OFF_EVENT, 0);
      apb(0, UES_OFF_EPST, 0);
      fa = 7'($urandom);
      apb(1, UES_OFF_ADDR, {25'h1ffffff, fa});
      host.tok(fa);
      apb(0, UES_OFF_ADDR, {25'h0, fa});
      chk("addr_match", 1, {31'h0, addr_match});
      host.tok(~fa);
      @(posedge sys_clk);
      chk("addr_match", 0, {31'h0, addr_match});
      apb(1, UES_OFF_EPST, '1);
      apb(0, 12'h010, 0);
      for (int n = 0; n < UES_NUM_EP; n++)
      begin
         ln = 10'($urandom_range(9, 7));
         mp = 10'($urandom_range(9, 7));
         host.ep(n[2:0], codes[n], ln, mp);
         ev = ev | (32'h1 << (16 + n)) | 32'h2;
         ep[8 + 3 * n +: 3] = codes[n];
         // OUT data is bounded by the endpoint payload, SETUP by eight bytes
         ep[7] = (codes[n] inside {3'h2, 3'h6}) ? (ln > mp)
            : (codes[n] == 3'h3 && ln > 10'h008);
         apb(0, UES_OFF_EVENT, ev);
         apb(0, UES_OFF_EPST, ep);
      end
      host.ep(3'h6, 3'h3, 10'h3ff, 10'h000);
      apb(0, UES_OFF_EPST, ep);
      host.ep(3'h2, 3'h6, 10'h00a, 10'h00c);
      ep[14 +: 3] = 3'h6;
      ep[7] = 1'b0;
      apb(0, UES_OFF_EPST, ep);
      host.ep(3'h2, 3'h2, 10'h00d, 10'h00c);
      ep[14 +: 3] = 3'h2;
      ep[7] = 1'b1;
      apb(0, UES_OFF_EPST, ep);
      host.ep(3'h4, 3'h3, 10'h009, 10'h3ff);
      ep[20 +: 3] = 3'h3;
      apb(0, UES_OFF_EPST, ep);
      apb(1, UES_OFF_EVENT, 32'h0002_0000);
      apb(0, UES_OFF_EVENT, ev & ~32'h0002_0000);
      apb(1, UES_OFF_EVENT, 32'h2);
      apb(0, UES_OFF_EVENT, 0);
      host.ep(3'h3, 3'h2, 10'h000, 10'h008);
      apb(1, UES_OFF_EVENT, 32'h0008_0000);
      apb(0, UES_OFF_EVENT, 0);
      host.bus(8'h80);
      host.ep(3'h0, 3'h3, 10'h008, 10'h008);
      apb(1, UES_OFF_EVENT, 32'h2);
      apb(0, UES_OFF_EVENT, 32'h8000_0000);
      apb(1, UES_OFF_EVENT, 32'h8000_0000);
      apb(0, UES_OFF_EVENT, 0);
      for (int i = 0; i < 3; i++)
      begin
         cr = 4'($urandom);
         host.bus({1'b0, i == 0, i == 1, i == 2, cr});
         apb(0, UES_OFF_EVENT, {28'h0, i == 0, i == 1, 1'b0, i == 2});
         apb(1, UES_OFF_EVENT, 32'hf);
         apb(0, UES_OFF_EVENT, 0);
      end
      chk("link_cause", {28'h0, cr}, {28'h0, cause});
      fork
         apb(1, UES_OFF_EVENT, 32'h8);
         begin
            @(posedge sys_clk);
            host.bus(8'h40);
         end
      join
      apb(0, UES_OFF_EVENT, 32'h8);
      test_done;
   end
endmodule
`default_nettype wire
